/* File: hw/scs_clock_select_top.sv */
// System clock selector with direct drive, prescaler, loop and wakeup paths.
// Assumes input clocks are slower than core_clk / 2; they are oversampled,
// so edges on sys_clk carry up to one core_clk period of quantisation.
// Function
// - Select code 11 drives external input directly
// - Direct drive keeps input duty cycle
// - Crystal bypass with factor one equals direct
// - Code 10 with bypass 1 selects prescaler
// - Prescaler input is crystal or internal source
// - Prescaler divides by divider field plus one
// - Factor one passes oscillator through unchanged
// - Largest divide factor is 1024
// - Code 10 with bypass 0 selects loop
// - Code 00 selects wakeup clock
`timescale 1ns/10ps
module scs_clock_select_top #(
  parameter int DIV_W = scs_pkg::DIV_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ext_clock_input,
  input wire logic crystal_input,
  input wire logic internal_osc_clk,
  input wire logic loop_clk,
  input wire logic wakeup_clk,
  input wire logic [1:0] clock_source_select,
  input wire logic oscillator_bypass,
  input wire logic osc_from_internal,
  input wire logic [DIV_W-1:0] output_divider_field,
  output logic sys_clk,
  output logic [4:0] active_source,
  output logic switch_busy
);
  logic [scs_pkg::NUM_IN-1:0] pins_in;
  logic [scs_pkg::NUM_IN-1:0] pins_s;
  scs_pkg::scs_src_e act_src_r;
  scs_pkg::scs_state_e state_r;
  logic act_int_r;
  logic [DIV_W-1:0] act_div_r;
  logic [DIV_W-1:0] cnt_r;
  logic osc_prev_r;
  logic sys_clk_r;

  // Every clock from outside passes two flops before use
  assign pins_in[scs_pkg::IN_EXT] = ext_clock_input;
  assign pins_in[scs_pkg::IN_XTAL] = crystal_input;
  assign pins_in[scs_pkg::IN_INT] = internal_osc_clk;
  assign pins_in[scs_pkg::IN_LOOP] = loop_clk;
  assign pins_in[scs_pkg::IN_WAKE] = wakeup_clk;

  scs_sync #(
    .W(scs_pkg::NUM_IN)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async_in(pins_in),
    .sync_out(pins_s)
  );

  // Decode the requested source from the configuration
  scs_pkg::scs_src_e req_src;
  always_comb
  begin
    case (clock_source_select)
      scs_pkg::SEL_DIRECT: req_src = scs_pkg::SRC_DIRECT;
      scs_pkg::SEL_LOOP_OR_PRESC:
        if (oscillator_bypass == scs_pkg::BYPASS_PRESC)
          req_src = scs_pkg::SRC_PRESC;
        else
          req_src = scs_pkg::SRC_LOOP;
      scs_pkg::SEL_WAKEUP: req_src = scs_pkg::SRC_WAKE;
      default: req_src = scs_pkg::SRC_OFF; // Undefined code holds clock low
    endcase
  end

  // A change of source, or of oscillator or factor while the prescaler is requested, needs a clean switch
  wire src_diff = (req_src != act_src_r);
  wire osc_diff = (req_src == scs_pkg::SRC_PRESC) &&
                  (osc_from_internal != act_int_r);
  wire div_diff = (req_src == scs_pkg::SRC_PRESC) &&
                  (output_divider_field != act_div_r);
  wire cfg_change = src_diff || osc_diff || div_diff;

  // Prescaler input: crystal or on-chip source
  wire osc_s = act_int_r ? pins_s[scs_pkg::IN_INT]
                         : pins_s[scs_pkg::IN_XTAL];
  wire osc_rise = osc_s && !osc_prev_r;

  // Factor is field plus one; 10 bits reach factor 1024
  wire [DIV_W:0] factor = {1'b0, act_div_r} + {{DIV_W{1'b0}}, 1'b1};
  wire [DIV_W:0] half = factor >> 1;
  wire cnt_wrap = (cnt_r == act_div_r);
  wire [DIV_W-1:0] cnt_inc = cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
  // Counter walks 0..field over rising edges of the oscillator
  wire [DIV_W-1:0] cnt_step = cnt_wrap ? {DIV_W{1'b0}} : cnt_inc;
  // High for the first half of the count; odd factors run short high
  wire div_high = ({1'b0, cnt_r} < half);
  // Factor one bypasses the counter to keep the oscillator's own duty
  wire presc_out = (act_div_r == {DIV_W{1'b0}}) ? osc_s : div_high;

  // Raw source before division, and the selected output level
  logic src_raw;
  logic src_out;
  always_comb
  begin
    case (act_src_r)
      scs_pkg::SRC_DIRECT:
      begin
        src_raw = pins_s[scs_pkg::IN_EXT];
        src_out = pins_s[scs_pkg::IN_EXT];
      end
      scs_pkg::SRC_PRESC:
      begin
        src_raw = osc_s;
        src_out = presc_out;
      end
      scs_pkg::SRC_LOOP:
      begin
        src_raw = pins_s[scs_pkg::IN_LOOP];
        src_out = pins_s[scs_pkg::IN_LOOP];
      end
      scs_pkg::SRC_WAKE:
      begin
        src_raw = pins_s[scs_pkg::IN_WAKE];
        src_out = pins_s[scs_pkg::IN_WAKE];
      end
      default:
      begin
        src_raw = 1'b0;
        src_out = 1'b0;
      end
    endcase
  end

  // Switch sequencer: let the old clock finish its high phase, then hold
  // low until the new source is low, so neither side gives a runt pulse
  scs_pkg::scs_state_e state_nxt;
  logic sys_clk_nxt;
  logic load_cfg;
  always_comb
  begin
    state_nxt = state_r;
    sys_clk_nxt = sys_clk_r;
    load_cfg = 1'b0;
    case (state_r)
      scs_pkg::ST_RUN:
      begin
        sys_clk_nxt = src_out;
        if (cfg_change)
          state_nxt = scs_pkg::ST_STOP;
      end
      scs_pkg::ST_STOP:
      begin
        // Old clock boundary: output already low and would stay low
        if (!sys_clk_r && !src_out)
        begin
          sys_clk_nxt = 1'b0;
          load_cfg = 1'b1;
          state_nxt = scs_pkg::ST_START;
        end
        else
          sys_clk_nxt = src_out;
      end
      scs_pkg::ST_START:
      begin
        // New clock boundary: start on its next rising edge
        sys_clk_nxt = 1'b0;
        if (!src_raw)
          state_nxt = scs_pkg::ST_RUN;
      end
      default:
      begin
        sys_clk_nxt = 1'b0;
        state_nxt = scs_pkg::ST_STOP;
      end
    endcase
  end

  // Sequencer and output registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= scs_pkg::ST_STOP;
      sys_clk_r <= scs_pkg::RST_OUT;
      osc_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      sys_clk_r <= sys_clk_nxt;
      osc_prev_r <= osc_s;
    end
  end

  // Active configuration; counter preset to its last step so the first
  // oscillator rise after the switch opens a full high phase
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      act_src_r <= scs_pkg::SRC_OFF;
      act_int_r <= 1'b0;
      act_div_r <= scs_pkg::RST_DIV;
      cnt_r <= scs_pkg::RST_DIV;
    end
    else if (ce)
    begin
      if (load_cfg)
      begin
        act_src_r <= req_src;
        act_int_r <= osc_from_internal;
        act_div_r <= output_divider_field;
        cnt_r <= output_divider_field;
      end
      // Keeps counting while stopping, else a high phase never ends
      else if (state_r != scs_pkg::ST_START && osc_rise)
        cnt_r <= cnt_step;
    end
  end

  assign sys_clk = sys_clk_r;
  assign active_source = act_src_r;
  assign switch_busy = (state_r != scs_pkg::ST_RUN);
endmodule

/* File: hw/scs_pkg.sv */
// Shared constants for the system clock selector and prescaler.
// Assumes all configuration inputs come from logic on core_clk.
package scs_pkg;
  // Core clock rate, for reference only; nothing here is timed
  localparam int CORE_CLK_PERIOD_NS = 40;

  // Clock source select codes
  localparam logic [1:0] SEL_WAKEUP = 2'h0;
  localparam logic [1:0] SEL_LOOP_OR_PRESC = 2'h2;
  localparam logic [1:0] SEL_DIRECT = 2'h3;

  // Oscillator bypass value that chooses the prescaler
  localparam logic BYPASS_PRESC = 1'h1;

  // Output divider field width and the largest divide factor
  localparam int DIV_W = 10;
  localparam int MAX_FACTOR = 1024;

  // Number of synchronised clock inputs and their bit positions
  localparam int NUM_IN = 5;
  localparam int IN_EXT = 0;
  localparam int IN_XTAL = 1;
  localparam int IN_INT = 2;
  localparam int IN_LOOP = 3;
  localparam int IN_WAKE = 4;

  // Active source, one-hot
  typedef enum logic [4:0] {
    SRC_OFF = 5'h01,
    SRC_WAKE = 5'h02,
    SRC_LOOP = 5'h04,
    SRC_PRESC = 5'h08,
    SRC_DIRECT = 5'h10
  } scs_src_e;

  // Switch sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_STOP = 3'h2,
    ST_START = 3'h4
  } scs_state_e;

  // Reset values
  localparam logic RST_OUT = 1'h0;
  localparam logic [DIV_W-1:0] RST_DIV = 10'h000;
endpackage

/* File: hw/scs_sync.sv */
// Two-stage synchroniser for a vector of independent pin-level signals.
// Assumes each bit is unrelated to the others; no word coherence given.
`timescale 1ns/10ps
module scs_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* File: verification/scs_clock_select_props.sv */
// Checker for the system clock selector outputs.
// Assumes it is bound onto scs_clock_select_top and that ce drops only
// while a divided prescaler path is active.
`timescale 1ns/10ps
module scs_clock_select_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ext_clock_input,
  input wire logic wakeup_clk,
  input wire logic [1:0] clock_source_select,
  input wire logic oscillator_bypass,
  input wire logic sys_clk,
  input wire logic [4:0] active_source,
  input wire logic switch_busy
);
  logic [4:0] exp_src;
  // Source that a settled switch must report
  assign exp_src = (clock_source_select == 2'h3) ? 5'h10 :
    (clock_source_select == 2'h0) ? 5'h02 :
    (clock_source_select == 2'h1) ? 5'h01 :
    (oscillator_bypass ? 5'h08 : 5'h04);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_map;
    !switch_busy && $stable({clock_source_select, oscillator_bypass})
      |-> active_source == exp_src;
  endproperty
  a_map: assert property (p_map) else $error("source mismatch");
  property p_onehot;
    $onehot(active_source);
  endproperty
  a_onehot: assert property (p_onehot) else $error("not one-hot");
  property p_off;
    active_source == 5'h01 |-> !sys_clk;
  endproperty
  a_off: assert property (p_off) else $error("off not low");
  // Pass-through latency is two sync stages plus the output register
  property p_direct;
    (!switch_busy)[*5] ##0 active_source == 5'h10
      |-> sys_clk == $past(ext_clock_input, 3);
  endproperty
  a_direct: assert property (p_direct) else $error("direct path");
  property p_wake;
    (!switch_busy)[*5] ##0 active_source == 5'h02
      |-> sys_clk == $past(wakeup_clk, 3);
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup path");
  property p_hi;
    $rose(sys_clk) |-> sys_clk[*3];
  endproperty
  a_hi: assert property (p_hi) else $error("short high");
  property p_lo;
    $fell(sys_clk) |-> (!sys_clk)[*3];
  endproperty
  a_lo: assert property (p_lo) else $error("short low");
  // The source may only change while the output rests low
  property p_hold;
    $changed(active_source) |-> !sys_clk && !$past(sys_clk);
  endproperty
  a_hold: assert property (p_hold) else $error("switch at high");
endmodule
bind scs_clock_select_top scs_clock_select_props u_props (.core_clk, .rst,
  .ext_clock_input, .wakeup_clk, .clock_source_select, .oscillator_bypass,
  .sys_clk, .active_source, .switch_busy);

/* File: verification/system_clock_select_prescaler_tb.sv */
// Self-checking bench for the clock selector: measures sys_clk periods.
// Assumes input clock edges fall 2 ns after core_clk rising edges.
`timescale 1ns/10ps
module system_clock_select_prescaler_tb;
  logic core_clk = 0, rst = 1, ce = 1, ext_clock_input = 0;
  logic crystal_input = 0, internal_osc_clk = 0, loop_clk = 0;
  logic wakeup_clk = 0, oscillator_bypass = 0, osc_from_internal = 0;
  logic [1:0] clock_source_select = 2'h3;
  logic [9:0] output_divider_field = 10'h000;
  logic sys_clk, switch_busy;
  logic [4:0] active_source;
  int fail_count = 0, checks = 0, seed = 32'h0b6e, cyc = 0;
  always #20 core_clk = ~core_clk;
  // Input clocks move just after core_clk rises, like all other stimulus;
  // periods are 12, 8, 10, 6 and 14 core cycles
  always @(posedge core_clk)
  begin
    #2;
    cyc++;
    if (cyc % 6 == 0)
      ext_clock_input = ~ext_clock_input;
    if (cyc % 4 == 0)
      crystal_input = ~crystal_input;
    if (cyc % 5 == 0)
      internal_osc_clk = ~internal_osc_clk;
    if (cyc % 3 == 0)
      loop_clk = ~loop_clk;
    if (cyc % 7 == 0)
      wakeup_clk = ~wakeup_clk;
  end
  scs_clock_select_top u_dut (.core_clk, .rst, .ce, .ext_clock_input,
    .crystal_input, .internal_osc_clk, .loop_clk, .wakeup_clk,
    .clock_source_select, .oscillator_bypass, .osc_from_internal,
    .output_divider_field, .sys_clk, .active_source, .switch_busy);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic [4:0] exp_src(input logic [1:0] s, input logic b);
    return s == 2'h3 ? 5'h10 : s == 2'h0 ? 5'h02 : s == 2'h1 ? 5'h01 :
      b ? 5'h08 : 5'h04;
  endfunction
  // Period in core cycles; divided paths scale the oscillator period
  function automatic int exp_per(input logic [1:0] s, input logic b,
    input logic i, input int d);
    return s == 2'h3 ? 12 : s == 2'h0 ? 14 : !b ? 6 : (i ? 10 : 8) * (d + 1);
  endfunction
  // High time in core cycles; divided paths stay high for factor/2 periods
  function automatic int exp_hi(input logic [1:0] s, input logic b,
    input logic i, input int d);
    return s == 2'h3 ? 6 : s == 2'h0 ? 7 : !b ? 3 :
      d == 0 ? (i ? 5 : 4) : (i ? 10 : 8) * ((d + 1) / 2);
  endfunction
  // Hold ce low for 20 cycles; sys_clk and active_source must stay frozen
  task freeze;
    logic h0;
    logic [4:0] a0;
    @(posedge core_clk);
    #2;
    ce = 1'b0;
    h0 = sys_clk;
    a0 = active_source;
    repeat (20)
    begin
      @(posedge core_clk);
      #1;
      chk(sys_clk, h0);
    end
    chk(active_source, a0);
    #1;
    ce = 1'b1;
  endtask
  // Apply a setting, wait out the switch, then time one output period and its high phase, or for code 01 check the output is low 40 cycles later
  task run(input logic [1:0] s, input logic b, input logic i, input int d);
    int n, r, t0, h;
    logic pv, ch;
    @(posedge core_clk);
    #2;
    ch = exp_src(s, b) !== exp_src(clock_source_select, oscillator_bypass);
    clock_source_select = s;
    oscillator_bypass = b;
    osc_from_internal = i;
    output_divider_field = d[9:0];
    @(posedge core_clk);
    #1;
    if (ch)
      chk(switch_busy, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    n = 0;
    while (switch_busy !== 1'b0 && n < 20000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(active_source, exp_src(s, b));
    if (s == 2'h1)
    begin
      repeat (40) @(posedge core_clk);
      chk(sys_clk, 1'b0);
      return;
    end
    r = 0;
    n = 0;
    t0 = 0;
    h = 0;
    pv = sys_clk;
    while (r < 3 && n < 30000)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (sys_clk === 1'b1 && pv === 1'b0)
        r++;
      if (r == 2 && t0 == 0)
        t0 = n;
      if (r == 2 && sys_clk === 1'b1)
        h++;
      pv = sys_clk;
    end
    chk(n - t0, exp_per(s, b, i, d));
    chk(h, exp_hi(s, b, i, d));
  endtask
  task test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence: every source code, both oscillators, edge factors
  initial
  begin
    repeat (8) @(posedge core_clk);
    #2;
    rst = 0;
    run(2'h3, 1'b0, 1'b0, 0);
    run(2'h0, 1'b0, 1'b0, 0);
    run(2'h2, 1'b0, 1'b0, 0);
    run(2'h2, 1'b1, 1'b0, 0);
    run(2'h2, 1'b1, 1'b1, 0);
    run(2'h2, 1'b1, 1'b1, 2);
    freeze;
    run(2'h1, 1'b0, 1'b0, 0);
    repeat (4) run(2'h2, 1'b1, 1'b0, $random(seed) & 15);
    run(2'h2, 1'b1, 1'b0, 1023);
    test_done;
  end
  // Watchdog sized well past the longest divided period
  initial
  begin
    #2000000;
    fail_count++;
    test_done;
  end
endmodule
